// *** src/rtc_alarm_wdog.sv ***
`timescale 1ns/1ns
`include "rtc_map.svh"
// Summary of operation
// [RULE1] repeat bits pick second, minute, hour, day, month or year match
// [RULE2] undefined repeat codes behave as once per second
// [RULE3] alarm match sets alarm_flag; with alarm_irq_enable it drives the pin
// [RULE4] pointer resting on flags address holds off the alarm interrupt
// [RULE5] flags read releases the pin and clears alarm_flag at D6
// [RULE6] host disables alarm by zeroing alarm date and repeat bits
// [RULE7] in backup mode alarm drives pin only with both enables set
// [RULE8] power-up clears both alarm enables; alarm then only sets the flag
// [RULE9] watchdog register: multiplier times resolution of 1/16, 1/4, 1, 4 s
// [RULE10] timeout may be off by one resolution unit
// [RULE11] unrestarted watchdog sets watchdog_flag and raises irq or reset
// [RULE12] watchdog_steer zero drives the pin, one pulses reset_out_n
// [RULE13] reset-steered timeout clears watchdog register and four enables
// [RULE14] kick pin edge or watchdog register write restarts the count
// [RULE15] writing 00h releases pin after irq timeout and stops watchdog
// [RULE16] flags read clears watchdog_flag at D7
// [RULE17] power-up clears the watchdog register, watchdog disabled
// [RULE18] irq-steered watchdog overrides frequency test on the pin
// [RULE19] four rate bits select square wave; zero gives no output
// [RULE20] sqw_enable gates the square wave pin on and off
// [RULE21] reset pin low on power fail and for hold time after
// [RULE22] rate codes 1..15 map 32768, 8192..1024, then 512 down to 1 Hz
// [RULE23] with all functions off the pin follows out_level_bit
// [RULE24] frequency test toggles the pin at 512 Hz when allowed
module rtc_alarm_wdog #(
  parameter int HOLD_CYC = `RTC_HOLD_CYC
) (
  // register side clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port from the serial front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] ptr_addr,
  // supply status pins
  input wire logic power_ok,
  input wire logic battery_mode,
  // oscillator domain and time counters
  input wire logic osc_clk,
  input wire logic tod_tick,
  input wire logic [6:0] tod_sec,
  input wire logic [6:0] tod_min,
  input wire logic [5:0] tod_hour,
  input wire logic [5:0] tod_date,
  input wire logic [4:0] tod_month,
  // pins
  input wire logic watchdog_kick_input,
  output logic irq_test_out_pin_o,
  output logic irq_test_out_pin_oe,
  output logic reset_out_n_o,
  output logic reset_out_n_oe,
  output logic sqw_pin
);
  localparam int CFG_W = 54;
  localparam logic [15:0] HOLD_LD = HOLD_CYC[15:0];

  ////////////////////////////////////////////////////////////////////////
  // register side
  logic [7:0] ctrl;
  logic [7:0] wdog;
  logic [7:0] sqw;
  logic [7:0] al [0:4];
  logic [1:0] wd_wr_cnt;
  logic af;
  logic watchdog_flag;
  logic al_pend;
  logic al_irq;
  logic pok_r;
  logic batt_r;
  logic [2:0] ev_ts;
  logic [2:0] ev_d;
  logic [2:0] ev_p;
  logic [2:0] ev_t;
  logic rd_flags;
  logic [CFG_W-1:0] cfg_src;
  logic [CFG_W-1:0] cfg_o;

  rtc_sync2 #(.W(5)) u_ref_sync (
    .clk(ref_clk),
    .d({power_ok, battery_mode, ev_t}),
    .q({pok_r, batt_r, ev_ts})
  );

  // event pulses: [0] alarm match, [1] timeout, [2] steered clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ev_d <= 3'h0;
    else
      ev_d <= ev_ts;
  end

  assign ev_p = ev_ts ^ ev_d;
  assign rd_flags = reg_rd && reg_addr == `RTC_A_FLAGS;

  // control register: out level and frequency test
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctrl <= `RTC_CTRL_RST;
    else
    begin
      if (reg_wr && reg_addr == `RTC_A_CTRL)
        ctrl <= reg_wdata;
      if (!pok_r || ev_p[2])
        ctrl[`RTC_B_FT] <= 1'b0; // [RULE13]
    end
  end

  // watchdog register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !pok_r)
      wdog <= `RTC_WDOG_RST; // [RULE17]
    else if (ev_p[2])
      wdog <= `RTC_WDOG_RST; // [RULE13]
    else if (reg_wr && reg_addr == `RTC_A_WDOG)
      wdog <= reg_wdata; // [RULE9]
  end

  // write counter marks every watchdog write as a restart
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wd_wr_cnt <= 2'h0;
    else if (reg_wr && reg_addr == `RTC_A_WDOG)
      wd_wr_cnt <= wd_wr_cnt + 2'h1; // [RULE14]
  end

  // alarm bytes, month byte also holds the enables
  for (genvar i = 0; i < 5; i++)
  begin : g_al
    always_ff @(posedge ref_clk)
    begin
      if (!resetn)
        al[i] <= `RTC_AL_RST;
      else
      begin
        if (reg_wr && reg_addr == `RTC_A_AL0 + 8'(i))
          al[i] <= reg_wdata;
        if (i == 0 && (!pok_r || ev_p[2]))
        begin
          al[i][`RTC_B_AFE] <= 1'b0; // [RULE8]
          al[i][`RTC_B_ABE] <= 1'b0; // [RULE8]
        end
        if (i == 0 && ev_p[2])
          al[i][`RTC_B_SQW_ENABLE] <= 1'b0; // [RULE13]
      end
    end
  end

  // square wave rate, low nibble reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sqw <= `RTC_SQW_RST;
    else if (reg_wr && reg_addr == `RTC_A_SQW)
      sqw <= {reg_wdata[7:4], 4'h0};
  end

  // alarm flag, a new match beats the read clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      af <= 1'b0;
    else if (ev_p[0])
      af <= 1'b1; // [RULE3]
    else if (rd_flags)
      af <= 1'b0; // [RULE5]
  end

  // watchdog flag, a new timeout beats the read clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      watchdog_flag <= 1'b0;
    else if (ev_p[1])
      watchdog_flag <= 1'b1; // [RULE11]
    else if (rd_flags)
      watchdog_flag <= 1'b0; // [RULE16]
  end

  // pending alarm interrupt
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      al_pend <= 1'b0;
    else if (ev_p[0] && al[0][`RTC_B_AFE] &&
             (!batt_r || al[0][`RTC_B_ABE]))
      al_pend <= 1'b1; // [RULE7]
    else if (rd_flags || !al[0][`RTC_B_AFE])
      al_pend <= 1'b0; // [RULE5]
  end

  // held off while the pointer rests on the flags register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      al_irq <= 1'b0;
    else
      al_irq <= al_pend && ptr_addr != `RTC_A_FLAGS; // [RULE4]
  end

  // read data, unmapped and reserved addresses read zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `RTC_A_CTRL)
        reg_rdata <= ctrl;
      else if (reg_addr == `RTC_A_WDOG)
        reg_rdata <= wdog;
      else if (reg_addr >= `RTC_A_AL0 && reg_addr <= `RTC_A_AL4)
        reg_rdata <= al[3'(reg_addr - `RTC_A_AL0)];
      else if (reg_addr == `RTC_A_FLAGS)
        reg_rdata <= {watchdog_flag, af, 6'h00};
      else if (reg_addr == `RTC_A_SQW)
        reg_rdata <= sqw;
      else
        reg_rdata <= 8'h00;
    end
  end

  // settings bundle handed to the oscillator domain
  assign cfg_src = {wdog, ctrl[`RTC_B_OUT], ctrl[`RTC_B_FT],
                    al[0][`RTC_B_AFE], al[0][`RTC_B_SQW_ENABLE], sqw[7:4],
                    wd_wr_cnt, al[1][`RTC_B_RPT5], al[1][`RTC_B_RPTH],
                    al[2][`RTC_B_RPTH], al[3][`RTC_B_RPTH],
                    al[4][`RTC_B_RPTH], al[0][4:0], al[1][5:0],
                    al[2][5:0], al[3][6:0], al[4][6:0]};

  ////////////////////////////////////////////////////////////////////////
  // crossings into the oscillator domain
  logic orst_n;
  logic pok_o;
  logic kick_s;
  logic alirq_o;

  rtc_sync2 #(.W(4)) u_osc_sync (
    .clk(osc_clk),
    .d({resetn, power_ok, watchdog_kick_input, al_irq}),
    .q({orst_n, pok_o, kick_s, alirq_o})
  );

  rtc_cdc_word #(.W(CFG_W)) u_cfg (
    .src_clk(ref_clk),
    .src_rst_n(resetn),
    .src_word(cfg_src),
    .dst_clk(osc_clk),
    .dst_rst_n(orst_n),
    .dst_word(cfg_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // oscillator domain
  logic [7:0] o_wd;
  logic o_out;
  logic o_ft;
  logic o_afe;
  logic o_sqw_enable;
  logic [3:0] o_rs;
  logic [1:0] o_wrcnt;
  logic [4:0] o_rpt;
  logic [4:0] o_month;
  logic [5:0] o_date;
  logic [5:0] o_hour;
  logic [6:0] o_min;
  logic [6:0] o_sec;

  assign {o_wd, o_out, o_ft, o_afe, o_sqw_enable, o_rs, o_wrcnt, o_rpt,
          o_month, o_date, o_hour, o_min, o_sec} = cfg_o;

  logic [17:0] pre;
  logic kick_d;
  logic [1:0] wr_seen;
  logic restart;
  logic tick;
  logic wd_exp;
  logic hit;
  logic [4:0] wd_cnt;
  logic [15:0] hcnt;
  logic [3:0] sel;
  rtc_pkg::rtc_wd_e wd_st;

  // free running prescaler, restarts do not clear it
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
      pre <= 18'h00000;
    else
      pre <= pre + 18'h00001; // [RULE10]
  end

  // restart sources: kick edge and register write
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
    begin
      kick_d <= 1'b0;
      wr_seen <= 2'h0;
    end
    else
    begin
      kick_d <= kick_s;
      wr_seen <= o_wrcnt;
    end
  end

  assign restart = (kick_s ^ kick_d) || o_wrcnt != wr_seen; // [RULE14]

  // resolution unit tick
  always_comb
  begin
    case (o_wd[1:0])
      2'b00: tick = &pre[`RTC_WD_U0-1:0]; // [RULE9]
      2'b01: tick = &pre[`RTC_WD_U1-1:0];
      2'b10: tick = &pre[`RTC_WD_U2-1:0];
      default: tick = &pre[`RTC_WD_U3-1:0];
    endcase
  end

  assign wd_exp = wd_st == rtc_pkg::WD_RUN && o_wd[6:2] != 5'h00 &&
                  !restart && tick && wd_cnt == 5'h01; // [RULE11]

  // watchdog state machine
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
    begin
      wd_st <= rtc_pkg::WD_IDLE;
      wd_cnt <= 5'h00;
    end
    else
    begin
      case (wd_st)
        rtc_pkg::WD_IDLE:
          if (restart && o_wd[6:2] != 5'h00)
          begin
            wd_st <= rtc_pkg::WD_RUN;
            wd_cnt <= o_wd[6:2]; // [RULE9]
          end
        rtc_pkg::WD_RUN:
          if (o_wd[6:2] == 5'h00)
            wd_st <= rtc_pkg::WD_IDLE;
          else if (restart)
            wd_cnt <= o_wd[6:2]; // [RULE14]
          else if (wd_exp)
          begin
            wd_cnt <= 5'h00;
            if (o_wd[`RTC_B_WDS])
              wd_st <= rtc_pkg::WD_RST; // [RULE12]
            else
              wd_st <= rtc_pkg::WD_IRQ; // [RULE12]
          end
          else if (tick)
            wd_cnt <= wd_cnt - 5'h01;
        rtc_pkg::WD_IRQ:
          if (o_wd == 8'h00)
            wd_st <= rtc_pkg::WD_IDLE; // [RULE15]
        default:
          if (o_wd == 8'h00)
            wd_st <= rtc_pkg::WD_IDLE; // [RULE13]
      endcase
    end
  end

  // alarm compare under the repeat code
  always_comb
  begin
    case (o_rpt)
      rtc_pkg::RPT_MIN: hit = tod_sec == o_sec; // [RULE1]
      rtc_pkg::RPT_HOUR: hit = tod_sec == o_sec && tod_min == o_min;
      rtc_pkg::RPT_DAY: hit = tod_sec == o_sec && tod_min == o_min &&
                              tod_hour == o_hour;
      rtc_pkg::RPT_MONTH: hit = tod_sec == o_sec && tod_min == o_min &&
                                tod_hour == o_hour && tod_date == o_date;
      // a zero date never matches, which keeps the alarm quiet
      rtc_pkg::RPT_YEAR: hit = tod_sec == o_sec && tod_min == o_min &&
                               tod_hour == o_hour && tod_date == o_date &&
                               tod_month == o_month; // [RULE6]
      default: hit = 1'b1; // [RULE2]
    endcase
  end

  // event toggles back to the register side
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
      ev_t <= 3'h0;
    else
    begin
      if (tod_tick && hit)
        ev_t[0] <= ~ev_t[0]; // [RULE3]
      if (wd_exp)
        ev_t[1] <= ~ev_t[1]; // [RULE11]
      if (wd_exp && o_wd[`RTC_B_WDS])
        ev_t[2] <= ~ev_t[2]; // [RULE13]
    end
  end

  // reset hold counter
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n || !pok_o)
      hcnt <= HOLD_LD; // [RULE21]
    else if (wd_exp && o_wd[`RTC_B_WDS])
      hcnt <= HOLD_LD; // [RULE12]
    else if (hcnt != 16'h0000)
      hcnt <= hcnt - 16'h0001;
  end

  // open drain reset pin
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
    begin
      reset_out_n_o <= 1'b0;
      reset_out_n_oe <= 1'b1;
    end
    else
    begin
      reset_out_n_o <= 1'b0;
      reset_out_n_oe <= !pok_o || hcnt != 16'h0000; // [RULE21]
    end
  end

  // open drain irq, test and out pin, watchdog first
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
    begin
      irq_test_out_pin_o <= 1'b0;
      irq_test_out_pin_oe <= 1'b0;
    end
    else
    begin
      irq_test_out_pin_o <= 1'b0;
      if (wd_st == rtc_pkg::WD_IRQ)
        irq_test_out_pin_oe <= 1'b1; // [RULE18]
      else if (alirq_o)
        irq_test_out_pin_oe <= 1'b1; // [RULE3]
      else if (o_ft && !o_afe &&
               (o_wd == 8'h00 || o_wd[`RTC_B_WDS]))
        irq_test_out_pin_oe <= !pre[`RTC_FT_BIT]; // [RULE24]
      else if (!o_ft && !o_afe && o_wd == 8'h00)
        irq_test_out_pin_oe <= !o_out; // [RULE23]
      else
        irq_test_out_pin_oe <= 1'b0;
    end
  end

  // prescaler bit for the rate, code one takes the fastest bit
  assign sel = (o_rs == 4'h1) ? 4'h0 : o_rs; // [RULE22]

  // square wave pin
  always_ff @(posedge osc_clk)
  begin
    if (!orst_n)
      sqw_pin <= 1'b0;
    else
      sqw_pin <= o_sqw_enable && o_rs != 4'h0 && pre[sel]; // [RULE19] [RULE20]
  end
endmodule

// *** src/rtc_map.svh ***
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// register offsets
`define RTC_A_CTRL 8'h08
`define RTC_A_WDOG 8'h09
`define RTC_A_AL0 8'h0A
`define RTC_A_AL4 8'h0E
`define RTC_A_FLAGS 8'h0F
`define RTC_A_RSV0 8'h10
`define RTC_A_RSVA 8'h11
`define RTC_A_RSVB 8'h12
`define RTC_A_SQW 8'h13
// field positions
`define RTC_B_WDF 7
`define RTC_B_AF 6
`define RTC_B_OUT 7
`define RTC_B_FT 6
`define RTC_B_AFE 7
`define RTC_B_SQW_ENABLE 6
`define RTC_B_ABE 5
`define RTC_B_WDS 7
`define RTC_B_RPTH 7
`define RTC_B_RPT5 6
// reset values
`define RTC_CTRL_RST 8'h80
`define RTC_WDOG_RST 8'h00
`define RTC_AL_RST 8'h00
`define RTC_SQW_RST 8'h00
// timing: oscillator domain runs at twice the crystal rate
`define RTC_OSC_HZ 65536
`define RTC_HOLD_MS 200
`define RTC_HOLD_CYC ((`RTC_OSC_HZ * `RTC_HOLD_MS + 999) / 1000)
`define RTC_FT_BIT 6
`define RTC_WD_U0 12
`define RTC_WD_U1 14
`define RTC_WD_U2 16
`define RTC_WD_U3 18
`endif

// *** src/rtc_pkg.sv ***
package rtc_pkg;
  // alarm repeat codes, {rpt5, rpt4, rpt3, rpt2, rpt1}
  typedef enum logic [4:0] {
    RPT_SEC = 5'h1F,
    RPT_MIN = 5'h1E,
    RPT_HOUR = 5'h1C,
    RPT_DAY = 5'h18,
    RPT_MONTH = 5'h10,
    RPT_YEAR = 5'h00
  } rtc_rpt_e;
  // watchdog states
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_IRQ = 2'b10,
    WD_RST = 2'b11
  } rtc_wd_e;
endpackage

// *** src/rtc_sync2.sv ***
`timescale 1ns/1ns
module rtc_sync2 #(
  parameter int W = 1
) (
  // destination clock
  input wire logic clk,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk)
  begin
    meta <= d;
    q <= meta;
  end
endmodule

// *** src/rtc_cdc_word.sv ***
`timescale 1ns/1ns
module rtc_cdc_word #(
  parameter int W = 8
) (
  // source side
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic [W-1:0] src_word,
  // destination side
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [W-1:0] dst_word
);
  logic [W-1:0] hold;
  logic req;
  logic ack;
  logic ack_s;
  logic req_s;

  rtc_sync2 #(.W(1)) u_ack_sync (
    .clk(src_clk),
    .d(ack),
    .q(ack_s)
  );

  rtc_sync2 #(.W(1)) u_req_sync (
    .clk(dst_clk),
    .d(req),
    .q(req_s)
  );

  // launch a new word only when the last one was taken
  always_ff @(posedge src_clk)
  begin
    if (!src_rst_n)
    begin
      hold <= '0;
      req <= 1'b0;
    end
    else if (req == ack_s && src_word != hold)
    begin
      hold <= src_word;
      req <= ~req;
    end
  end

  // hold is stable while req and ack differ
  always_ff @(posedge dst_clk)
  begin
    if (!dst_rst_n)
    begin
      dst_word <= '0;
      ack <= 1'b0;
    end
    else if (req_s != ack)
    begin
      dst_word <= hold;
      ack <= req_s;
    end
  end
endmodule

// *** testbench/rtc_alarm_wdog_props.sv ***
`timescale 1ns/1ns
// pin and register side checks of the alarm and watchdog block
module rtc_wdog_props (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic osc_clk,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic irq_test_out_pin_o,
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe
);
  // reset pin held low for a run of cycles
  sequence s_rst_low8;
    reset_out_n_oe [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_holds: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_flags_format: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    reg_rd && reg_addr == 8'h0F |=> reg_rdata[5:0] == 6'h00)
    else $error("flags low bits not zero");
  a_sqw_format: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    reg_rd && reg_addr == 8'h13 |=> reg_rdata[3:0] == 4'h0)
    else $error("rate low bits not zero");
  a_rst_hold: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> s_rst_low8) else $error("reset pin released early");
  a_rst_release: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> ##[1:80] !reset_out_n_oe)
    else $error("reset pin never released");
  a_rst_pulse: assert property (
    @(posedge osc_clk) disable iff (!resetn)
    $rose(reset_out_n_oe) |-> s_rst_low8) else $error("reset pulse short");
  a_irq_drain: assert property (
    @(posedge osc_clk) disable iff (!resetn)
    irq_test_out_pin_o == 1'b0) else $error("irq pin driven high");
  a_rst_drain: assert property (
    @(posedge osc_clk) disable iff (!resetn)
    reset_out_n_o == 1'b0) else $error("reset pin driven high");
endmodule

// *** testbench/rtc_host_model.sv ***
`timescale 1ns/1ns
// host side of the register port, one byte per access
module rtc_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  // idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one write strobe, data scrambled once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read strobe, data taken by the bench a cycle later
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
endmodule

// *** testbench/rtc_alarm_watchdog_sqw_tb.sv ***
`timescale 1ns/1ns
module rtc_alarm_watchdog_sqw_tb;
  logic ref_clk = 1'b0;
  logic osc_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, irq_o, irq_oe, rst_o, rst_oe, sqw_pin;
  logic [7:0] ptr_addr = 8'h00;
  logic power_ok = 1'b1;
  logic battery_mode = 1'b0;
  logic tod_tick = 1'b0;
  logic kick = 1'b0;
  logic [6:0] tod_sec = 7'h00;
  logic [6:0] tod_min = 7'h00;
  logic [5:0] tod_hour = 6'h00;
  logic [5:0] tod_date = 6'h01;
  logic [4:0] tod_month = 5'h00;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  integer seed = 32'hFD6489B5;
  ////////////////////////////////////////////////////////////////////////////
  // clocks, the oscillator unrelated in phase
  initial
    forever #25 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #16 osc_clk = ~osc_clk;
  end
  rtc_host_model host (.clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  rtc_alarm_wdog #(.HOLD_CYC(20)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ptr_addr(ptr_addr),
    .power_ok(power_ok), .battery_mode(battery_mode), .osc_clk(osc_clk),
    .tod_tick(tod_tick), .tod_sec(tod_sec), .tod_min(tod_min),
    .tod_hour(tod_hour), .tod_date(tod_date), .tod_month(tod_month),
    .watchdog_kick_input(kick), .irq_test_out_pin_o(irq_o),
    .irq_test_out_pin_oe(irq_oe), .reset_out_n_o(rst_o),
    .reset_out_n_oe(rst_oe), .sqw_pin(sqw_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // note the expected byte, then read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  // read data appears the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rd_d)
      check("rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // wait for a pin level, or with hold watch that it never leaves it
  task automatic wait_pin(input logic rst, input logic v, input int n,
    input logic hold);
    logic s;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      s = rst ? rst_oe : irq_oe;
      if ((s === v) != hold)
        break;
    end
    check(rst ? "rst_oe" : "irq_oe", {7'h00, s}, {7'h00, v});
  endtask
  task automatic tick();
    repeat (40) @(posedge ref_clk);
    @(posedge osc_clk) tod_tick <= 1'b1;
    @(posedge osc_clk) tod_tick <= 1'b0;
  endtask
  // alarm at second 30, date 1, month 1
  task automatic set_alarm(input logic [4:0] c, input logic [7:0] en);
    host.wr(8'h0B, {c[3], c[4], 6'h01});
    host.wr(8'h0C, {c[2], 7'h00});
    host.wr(8'h0D, {c[1], 7'h00});
    host.wr(8'h0E, {c[0], 7'h30});
    host.wr(8'h0A, en);
  endtask
  // counts square wave edges over 64 oscillator cycles
  task automatic sqw(input logic [7:0] rate, input logic [7:0] en,
    input logic [7:0] e);
    logic [7:0] n;
    logic p;
    host.wr(8'h13, rate);
    host.wr(8'h0A, en);
    repeat (40) @(posedge ref_clk);
    n = 8'h00;
    @(negedge osc_clk) p = sqw_pin;
    repeat (64)
    begin
      @(negedge osc_clk);
      n += {7'h00, sqw_pin !== p};
      p = sqw_pin;
    end
    check("sqw", n, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    static logic [4:0] codes [4] = '{5'h1F, 5'h15, 5'h1E, 5'h00};
    logic [7:0] d;
    logic al;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    host.wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h09, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      host.wr(8'h13, d);
      rd(8'h13, {d[7:4], 4'h0});
    end
    // repeat codes, undefined one acting as every second
    foreach (codes[i])
    begin
      al = codes[i] == 5'h1F || codes[i] == 5'h15;
      set_alarm(codes[i], 8'h81);
      tick();
      wait_pin(1'b0, al, 200, !al);
      rd(8'h0F, {1'b0, al, 6'h00});
      wait_pin(1'b0, 1'b0, 100, 1'b0);
    end
    // pointer resting on the flags address holds the pin off
    set_alarm(5'h1F, 8'h81);
    ptr_addr <= 8'h0F;
    tick();
    wait_pin(1'b0, 1'b0, 100, 1'b1);
    ptr_addr <= 8'h00;
    wait_pin(1'b0, 1'b1, 100, 1'b0);
    rd(8'h0F, 8'h40);
    // backup mode needs both enables
    battery_mode <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      set_alarm(5'h1F, {2'b10, i[0], 5'h01});
      tick();
      wait_pin(1'b0, i[0], 200, !i[0]);
      rd(8'h0F, 8'h40);
    end
    battery_mode <= 1'b0;
    for (int i = 11; i < 15; i++)
      host.wr(i[7:0], 8'h00);
    tick();
    wait_pin(1'b0, 1'b0, 200, 1'b1);
    rd(8'h0F, 8'h00);
    // kicked watchdog with frequency test on, then timeout
    host.wr(8'h0A, 8'h00);
    host.wr(8'h09, 8'h08);
    host.wr(8'h08, 8'hC0);
    repeat (6)
    begin
      wait_pin(1'b0, 1'b0, 1500, 1'b1);
      kick <= ~kick;
    end
    wait_pin(1'b0, 1'b1, 6000, 1'b0);
    wait_pin(1'b0, 1'b1, 200, 1'b1);
    host.wr(8'h08, 8'h80);
    rd(8'h0F, 8'h80);
    host.wr(8'h09, 8'h00);
    wait_pin(1'b0, 1'b0, 100, 1'b0);
    wait_pin(1'b0, 1'b0, 6000, 1'b1);
    // reset steered timeout clears the enables
    host.wr(8'h08, 8'hC0);
    host.wr(8'h0A, 8'hE1);
    host.wr(8'h09, 8'h84);
    wait_pin(1'b1, 1'b1, 4000, 1'b0);
    wait_pin(1'b1, 1'b0, 100, 1'b0);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h01);
    rd(8'h08, 8'h80);
    rd(8'h0F, 8'h80);
    host.wr(8'h08, 8'h00);
    wait_pin(1'b0, 1'b1, 100, 1'b0);
    host.wr(8'h08, 8'h80);
    wait_pin(1'b0, 1'b0, 100, 1'b0);
    // frequency test toggles the pin, each level 64 oscillator cycles
    host.wr(8'h08, 8'h40);
    wait_pin(1'b0, 1'b1, 200, 1'b0);
    wait_pin(1'b0, 1'b0, 200, 1'b0);
    wait_pin(1'b0, 1'b0, 30, 1'b1);
    // rate table and gating
    sqw(8'h10, 8'h40, 8'd64);
    sqw(8'h20, 8'h40, 8'd16);
    sqw(8'h30, 8'h40, 8'd8);
    sqw(8'h00, 8'h40, 8'd0);
    sqw(8'h10, 8'h00, 8'd0);
    // power fail pulls the reset pin and clears the watchdog register and both alarm enables, square wave enable kept
    host.wr(8'h0A, 8'hE0);
    host.wr(8'h09, 8'h7C);
    power_ok <= 1'b0;
    wait_pin(1'b1, 1'b1, 40, 1'b0);
    power_ok <= 1'b1;
    wait_pin(1'b1, 1'b0, 200, 1'b0);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h40);
    repeat (2) @(posedge ref_clk);
    wrap_up();
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
endmodule
bind rtc_alarm_wdog rtc_wdog_props chk (.ref_clk, .resetn, .osc_clk,
  .reg_addr, .reg_rd, .reg_rdata, .irq_test_out_pin_o, .reset_out_n_o,
  .reset_out_n_oe);
